/* File: src/adci_defines.svh */
`ifndef ADCI_DEFINES_SVH
`define ADCI_DEFINES_SVH

// register indices; byte address is four times the index
`define ADCI_IDX_INPUT_CTRL 8'h10
`define ADCI_IDX_EVENT_CTRL 8'h14
`define ADCI_IDX_IRQ_EN_CLR 8'h16
`define ADCI_IDX_IRQ_EN_SET 8'h17
`define ADCI_IDX_IRQ_FLAG 8'h18

// input control fields
`define ADCI_POS_LSB 0
`define ADCI_POS_MSB 4
`define ADCI_NEG_LSB 8
`define ADCI_NEG_MSB 12

// event control fields
`define ADCI_EV_CONVERT_IN 0
`define ADCI_EV_FLUSH_IN 1
`define ADCI_EV_DONE_OUT 4
`define ADCI_EV_RANGE_OUT 5
`define ADCI_EV_MASK 8'h33

// interrupt source bits
`define ADCI_IRQ_CONV_DONE 0
`define ADCI_IRQ_OVERRUN 1
`define ADCI_IRQ_RANGE 2
`define ADCI_IRQ_SYNC 3
`define ADCI_IRQ_MASK 8'h0F

// reset values
`define ADCI_RST_INPUT_CTRL 13'h0000
`define ADCI_RST_EVENT_CTRL 8'h00
`define ADCI_RST_IRQ_EN 4'h0
`define ADCI_RST_IRQ_FLAG 4'h0

// multiplexer codes
`define ADCI_POS_PIN_LAST 5'h13
`define ADCI_POS_TEMP 5'h18
`define ADCI_POS_BANDGAP 5'h19
`define ADCI_POS_CORE_Q 5'h1A
`define ADCI_POS_IO_Q 5'h1B
`define ADCI_POS_CONV_OUT 5'h1C
`define ADCI_NEG_PIN_LAST 5'h07
`define ADCI_NEG_GND 5'h18
`define ADCI_NEG_IO_GND 5'h19

// bus answers
`define ADCI_RESP_OKAY 2'h0
`define ADCI_RESP_SLVERR 2'h2

`endif

/* File: src/adci_pkg.sv */
package adci_pkg;

   typedef enum logic [2:0] {
      ADCI_POS_PIN = 3'h0,
      ADCI_POS_TEMPERATURE = 3'h1,
      ADCI_POS_BANDGAP_REF = 3'h2,
      ADCI_POS_QUARTER_CORE = 3'h3,
      ADCI_POS_QUARTER_IO = 3'h4,
      ADCI_POS_CONVERTER = 3'h5,
      ADCI_POS_RESERVED = 3'h7
   } adci_pos_src_t;

   typedef enum logic [1:0] {
      ADCI_NEG_PIN = 2'h0,
      ADCI_NEG_INT_GROUND = 2'h1,
      ADCI_NEG_IO_GROUND = 2'h2,
      ADCI_NEG_RESERVED = 2'h3
   } adci_neg_src_t;

   // gray coded along idle -> flush -> start
   typedef enum logic [1:0] {
      ADCI_SEQ_IDLE = 2'h0,
      ADCI_SEQ_FLUSH = 2'h1,
      ADCI_SEQ_START = 2'h3
   } adci_seq_t;

endpackage

/* File: src/adci_sel_decode.sv */
`timescale 1ns/1ns
`include "adci_defines.svh"

module adci_sel_decode
   import adci_pkg::*;
(
   input wire logic [4:0] pos_code,
   input wire logic [4:0] neg_code,
   output adci_pos_src_t pos_src,
   output adci_neg_src_t neg_src,
   output logic needs_sample_time
);

   wire pos_is_pin = pos_code <= `ADCI_POS_PIN_LAST;
   wire neg_is_pin = neg_code <= `ADCI_NEG_PIN_LAST;

   // codes 0x14-0x17 and above 0x1C are reserved
   assign pos_src =
      pos_is_pin ? ADCI_POS_PIN :
      (pos_code == `ADCI_POS_TEMP) ? ADCI_POS_TEMPERATURE :
      (pos_code == `ADCI_POS_BANDGAP) ? ADCI_POS_BANDGAP_REF :
      (pos_code == `ADCI_POS_CORE_Q) ? ADCI_POS_QUARTER_CORE :
      (pos_code == `ADCI_POS_IO_Q) ? ADCI_POS_QUARTER_IO :
      (pos_code == `ADCI_POS_CONV_OUT) ? ADCI_POS_CONVERTER :
      ADCI_POS_RESERVED;

   assign neg_src =
      neg_is_pin ? ADCI_NEG_PIN :
      (neg_code == `ADCI_NEG_GND) ? ADCI_NEG_INT_GROUND :
      (neg_code == `ADCI_NEG_IO_GND) ? ADCI_NEG_IO_GROUND :
      ADCI_NEG_RESERVED;

   // sampling time must be programmed for these two sources
   assign needs_sample_time = (pos_code == `ADCI_POS_TEMP) ||
      (pos_code == `ADCI_POS_BANDGAP);

endmodule

/* File: src/adci_ctrl.sv */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "adci_defines.svh"

module adci_ctrl
   import adci_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic EVENT_IN,
   input wire logic CONV_DONE,
   input wire logic RANGE_MATCH,
   input wire logic DOMAIN_SYNC_DONE,
   input wire logic RESULT_READ,
   output logic CONV_START,
   output logic CONV_FLUSH,
   output logic CONV_DONE_EVENT,
   output logic RANGE_MATCH_EVENT,
   output logic [4:0] POS_INPUT_SELECT,
   output logic [4:0] NEG_INPUT_SELECT,
   output adci_pos_src_t POS_SOURCE,
   output adci_neg_src_t NEG_SOURCE,
   output logic SAMPLE_TIME_NEEDED,
   output logic IRQ
);

   if (ADDR_W < 7 || ADDR_W > 32)
      $error("adci_ctrl: ADDR_W must lie in 7..32");

   localparam logic [ADDR_W-1:0] A_INPUT =
      ADDR_W'({`ADCI_IDX_INPUT_CTRL, 2'b00});
   localparam logic [ADDR_W-1:0] A_EVENT =
      ADDR_W'({`ADCI_IDX_EVENT_CTRL, 2'b00});
   localparam logic [ADDR_W-1:0] A_EN_CLR =
      ADDR_W'({`ADCI_IDX_IRQ_EN_CLR, 2'b00});
   localparam logic [ADDR_W-1:0] A_EN_SET =
      ADDR_W'({`ADCI_IDX_IRQ_EN_SET, 2'b00});
   localparam logic [ADDR_W-1:0] A_FLAG =
      ADDR_W'({`ADCI_IDX_IRQ_FLAG, 2'b00});

   // reset image of the input control word
   localparam logic [12:0] RST_INPUT = `ADCI_RST_INPUT_CTRL;

   // register state
   logic [4:0] pos_sel;
   logic [4:0] neg_sel;
   logic [7:0] event_control;
   logic [3:0] irq_enable;
   logic [3:0] irq_flag;
   logic result_unread;
   adci_seq_t seq;
   adci_seq_t next_seq;

   // bus slave state
   logic aw_full;
   logic w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // write channel decode
   wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   wire w_take = S_AXI_WVALID && S_AXI_WREADY;
   wire next_aw_full = aw_full || aw_take;
   wire next_w_full = w_full || w_take;
   wire wr_do = aw_full && w_full && !S_AXI_BVALID;
   wire lane0 = w_strb[0];
   wire lane1 = w_strb[1];
   wire wr_input = wr_do && aw_addr == A_INPUT;
   wire wr_event = wr_do && aw_addr == A_EVENT && lane0;
   wire wr_en_clr = wr_do && aw_addr == A_EN_CLR && lane0;
   wire wr_en_set = wr_do && aw_addr == A_EN_SET && lane0;
   wire wr_flag = wr_do && aw_addr == A_FLAG && lane0;
   wire wr_mapped = aw_addr == A_INPUT || aw_addr == A_EVENT ||
      aw_addr == A_EN_CLR || aw_addr == A_EN_SET || aw_addr == A_FLAG;
   wire [3:0] wbits = w_data[3:0] & 4'(`ADCI_IRQ_MASK);

   // write data fields; reserved bits never reach a register
   wire [4:0] wr_pos = w_data[`ADCI_POS_MSB:`ADCI_POS_LSB];
   wire [4:0] wr_neg = w_data[`ADCI_NEG_MSB:`ADCI_NEG_LSB];
   wire [7:0] wr_events = w_data[7:0] & `ADCI_EV_MASK;

   // read channel decode
   wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
   wire rd_input = S_AXI_ARADDR == A_INPUT;
   wire rd_event = S_AXI_ARADDR == A_EVENT;
   wire rd_en = S_AXI_ARADDR == A_EN_CLR ||
      S_AXI_ARADDR == A_EN_SET;
   wire rd_flag = S_AXI_ARADDR == A_FLAG;
   wire rd_mapped = rd_input || rd_event || rd_en || rd_flag;
   wire [31:0] rd_word =
      rd_input ? {19'h00000, neg_sel, 3'h0, pos_sel} :
      rd_event ? {24'h000000, event_control} :
      rd_en ? {28'h0000000, irq_enable} :
      rd_flag ? {28'h0000000, irq_flag} :
      32'h00000000;

   // hardware events; a set wins over a clear in the same cycle
   wire overrun_hit = CONV_DONE && result_unread && !RESULT_READ;
   wire [3:0] flag_set = {DOMAIN_SYNC_DONE, RANGE_MATCH, overrun_hit,
      CONV_DONE};
   wire [3:0] flag_clr = (wr_flag ? wbits : 4'h0) |
      {1'b0, RESULT_READ, 1'b0, RESULT_READ};
   wire [3:0] next_flag = (irq_flag & ~flag_clr) | flag_set;
   // one enable set serves both the set and the clear address
   wire [3:0] next_enable = (irq_enable & ~(wr_en_clr ? wbits : 4'h0)) |
      (wr_en_set ? wbits : 4'h0);
   wire next_unread = CONV_DONE || (result_unread && !RESULT_READ);

   wire flush_req = EVENT_IN && event_control[`ADCI_EV_FLUSH_IN];
   wire start_req = EVENT_IN && event_control[`ADCI_EV_CONVERT_IN];

   // output events fire on the edge that also sets the matching flag
   wire done_event = CONV_DONE && event_control[`ADCI_EV_DONE_OUT];
   wire range_event = RANGE_MATCH &&
      event_control[`ADCI_EV_RANGE_OUT];
   wire flush_out = next_seq == ADCI_SEQ_FLUSH;
   wire start_out = next_seq == ADCI_SEQ_START;
   // request follows the next state, so a clear withdraws it at once
   wire irq_next = |(next_flag & next_enable);

   // input event sequencing: flush pulse, then start pulse
   always_comb
   begin
      next_seq = ADCI_SEQ_IDLE;
      case (seq)
         ADCI_SEQ_IDLE:
            if (flush_req)
               next_seq = ADCI_SEQ_FLUSH;
            else if (start_req)
               next_seq = ADCI_SEQ_START;
         ADCI_SEQ_FLUSH:
            next_seq = ADCI_SEQ_START;
         ADCI_SEQ_START:
            next_seq = flush_req ? ADCI_SEQ_FLUSH : ADCI_SEQ_IDLE;
         default:
            next_seq = ADCI_SEQ_IDLE;
      endcase
   end

   adci_sel_decode u_decode (
      .pos_code(pos_sel),
      .neg_code(neg_sel),
      .pos_src(POS_SOURCE),
      .neg_src(NEG_SOURCE),
      .needs_sample_time(SAMPLE_TIME_NEEDED)
   );

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else
      begin
         aw_full <= next_aw_full && !wr_do;
         w_full <= next_w_full && !wr_do;
         S_AXI_AWREADY <= !(next_aw_full && !wr_do);
         S_AXI_WREADY <= !(next_w_full && !wr_do);
         if (aw_take)
            aw_addr <= S_AXI_AWADDR;
         if (w_take)
         begin
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `ADCI_RESP_OKAY;
      end
      else if (wr_do)
      begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= wr_mapped ? `ADCI_RESP_OKAY : `ADCI_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
         S_AXI_BVALID <= 1'b0;
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `ADCI_RESP_OKAY;
      end
      else if (ar_take)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_word;
         S_AXI_RRESP <= rd_mapped ? `ADCI_RESP_OKAY : `ADCI_RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
      else if (!S_AXI_RVALID)
         S_AXI_ARREADY <= 1'b1;
   end

   // configuration registers
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         pos_sel <= RST_INPUT[`ADCI_POS_MSB:`ADCI_POS_LSB];
         neg_sel <= RST_INPUT[`ADCI_NEG_MSB:`ADCI_NEG_LSB];
         event_control <= `ADCI_RST_EVENT_CTRL;
         irq_enable <= `ADCI_RST_IRQ_EN;
      end
      else
      begin
         if (wr_input && lane0)
            pos_sel <= wr_pos;
         if (wr_input && lane1)
            neg_sel <= wr_neg;
         if (wr_event)
            event_control <= wr_events;
         irq_enable <= next_enable;
      end
   end

   // status, events and outputs
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         irq_flag <= `ADCI_RST_IRQ_FLAG;
         result_unread <= 1'b0;
         seq <= ADCI_SEQ_IDLE;
         CONV_START <= 1'b0;
         CONV_FLUSH <= 1'b0;
         CONV_DONE_EVENT <= 1'b0;
         RANGE_MATCH_EVENT <= 1'b0;
         POS_INPUT_SELECT <= 5'h00;
         NEG_INPUT_SELECT <= 5'h00;
         IRQ <= 1'b0;
      end
      else
      begin
         irq_flag <= next_flag;
         result_unread <= next_unread;
         seq <= next_seq;
         CONV_FLUSH <= flush_out;
         CONV_START <= start_out;
         CONV_DONE_EVENT <= done_event;
         RANGE_MATCH_EVENT <= range_event;
         POS_INPUT_SELECT <= pos_sel;
         NEG_INPUT_SELECT <= neg_sel;
         IRQ <= irq_next;
      end
   end

endmodule

/* File: testbench/adci_ctrl_monitor.sv */
`timescale 1ns/1ns

module adci_ctrl_monitor
   import adci_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic EVENT_IN,
   input wire logic CONV_DONE,
   input wire logic RANGE_MATCH,
   input wire logic CONV_START,
   input wire logic CONV_FLUSH,
   input wire logic CONV_DONE_EVENT,
   input wire logic RANGE_MATCH_EVENT,
   input wire logic [4:0] POS_INPUT_SELECT,
   input wire logic [4:0] NEG_INPUT_SELECT,
   input wire adci_pos_src_t POS_SOURCE,
   input wire adci_neg_src_t NEG_SOURCE,
   input wire logic SAMPLE_TIME_NEEDED
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   done_event_cause_a: assert property (
      CONV_DONE_EVENT |-> $past(CONV_DONE)) else $error("stray done event");
   range_event_cause_a: assert property (
      RANGE_MATCH_EVENT |-> $past(RANGE_MATCH))
      else $error("stray range event");
   event_one_cycle_a: assert property (
      CONV_DONE_EVENT |=> !CONV_DONE_EVENT || $past(CONV_DONE))
      else $error("done event too long");
   flush_then_start_a: assert property (
      CONV_FLUSH |=> CONV_START) else $error("no start after flush");
   start_cause_a: assert property (
      CONV_START |-> $past(EVENT_IN) || $past(CONV_FLUSH))
      else $error("start without cause");
   sample_time_a: assert property (
      SAMPLE_TIME_NEEDED == (POS_SOURCE inside
      {ADCI_POS_TEMPERATURE, ADCI_POS_BANDGAP_REF}))
      else $error("sample time flag wrong");
   neg_io_gnd_a: assert property (
      NEG_INPUT_SELECT == 5'h19 |-> $past(NEG_SOURCE) == ADCI_NEG_IO_GROUND)
      else $error("io ground decode wrong");
   pos_pin_a: assert property (
      POS_INPUT_SELECT <= 5'h13 |-> $past(POS_SOURCE) == ADCI_POS_PIN)
      else $error("pin decode wrong");

   cover property (CONV_FLUSH ##1 CONV_START);
   cover property (CONV_DONE_EVENT);
   cover property (SAMPLE_TIME_NEEDED);
endmodule

/* File: testbench/adci_far_side.sv */
`timescale 1ns/1ns

module adci_far_side
(
   input wire logic clk,
   output logic [4:0] pulse
);
   initial pulse = 5'h00;

   // one clock wide strobe toward the block, launched after an edge
   task fire(input logic [4:0] m);
      @(posedge clk);
      pulse <= m;
      @(posedge clk);
      pulse <= 5'h00;
   endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ns

module testbench
   import adci_pkg::*;
;
   logic clk, rst, awv, wv, brdy, arv, rrdy, awr, wr_r, bv, arr, rv;
   logic st, fl, dev, rev, stn, irq;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdata, rd_val;
   logic [1:0] bresp, rresp, resp;
   logic [4:0] p, psel, nsel, c;
   logic [3:0] ws;
   adci_pos_src_t ps;
   adci_neg_src_t ns;
   int bad_count, checks_done;

   adci_far_side far (.clk(clk), .pulse(p));

   adci_ctrl uut (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rrdy), .EVENT_IN(p[0]), .CONV_DONE(p[1]),
      .RANGE_MATCH(p[2]), .DOMAIN_SYNC_DONE(p[3]), .RESULT_READ(p[4]),
      .CONV_START(st), .CONV_FLUSH(fl), .CONV_DONE_EVENT(dev),
      .RANGE_MATCH_EVENT(rev), .POS_INPUT_SELECT(psel),
      .NEG_INPUT_SELECT(nsel), .POS_SOURCE(ps), .NEG_SOURCE(ns),
      .SAMPLE_TIME_NEEDED(stn), .IRQ(irq));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task finish_test;
      if (bad_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      while (!(ta && tw && bv === 1'b1))
      begin
         @(posedge clk);
         if (!ta && awr === 1'b1)
         begin
            ta = 1'b1;
            awv <= 1'b0;
         end
         if (!tw && wr_r === 1'b1)
         begin
            tw = 1'b1;
            wv <= 1'b0;
         end
      end
      resp = bresp;
      brdy <= 1'b0;
   endtask

   task rd(input logic [7:0] a);
      logic ta;
      ta = 1'b0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      while (!(ta && rv === 1'b1))
      begin
         @(posedge clk);
         if (!ta && arr === 1'b1)
         begin
            ta = 1'b1;
            arv <= 1'b0;
         end
      end
      rd_val = rdata;
      resp = rresp;
      rrdy <= 1'b0;
   endtask

   task rc(input logic [7:0] a, input logic [31:0] e, input string n);
      rd(a);
      chk(n, e, rd_val);
   endtask

   task step;
      @(posedge clk);
      #1;
   endtask

   task ev(input logic [4:0] m);
      far.fire(m);
      #1;
   endtask

   function automatic logic [31:0] pexp(input logic [4:0] k);
      case (k)
         5'h18: pexp = 32'(ADCI_POS_TEMPERATURE);
         5'h19: pexp = 32'(ADCI_POS_BANDGAP_REF);
         5'h1A: pexp = 32'(ADCI_POS_QUARTER_CORE);
         5'h1B: pexp = 32'(ADCI_POS_QUARTER_IO);
         5'h1C: pexp = 32'(ADCI_POS_CONVERTER);
         default: pexp = 32'(k <= 5'h13 ? ADCI_POS_PIN : ADCI_POS_RESERVED);
      endcase
   endfunction

   function automatic logic [31:0] nexp(input logic [4:0] k);
      case (k)
         5'h18: nexp = 32'(ADCI_NEG_INT_GROUND);
         5'h19: nexp = 32'(ADCI_NEG_IO_GROUND);
         default: nexp = 32'(k <= 5'h07 ? ADCI_NEG_PIN : ADCI_NEG_RESERVED);
      endcase
   endfunction

   initial
   begin
      #200000;
      bad_count++;
      finish_test;
   end

   initial
   begin
      {awv, wv, brdy, arv, rrdy, awa, ara, wd} = '0;
      ws = 4'hF;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rc(8'h40, 32'h0, "input_control");
      rc(8'h50, 32'h0, "event_control");
      rc(8'h58, 32'h0, "irq_enable_clear");
      rc(8'h5C, 32'h0, "irq_enable_set");
      rc(8'h60, 32'h0, "irq_flag");
      // reserved bits written high on purpose
      wr(8'h40, 32'h0000FFFF);
      rc(8'h40, 32'h00001F1F, "input_control");
      wr(8'h50, 32'h000000FF);
      rc(8'h50, 32'h00000033, "event_control");
      wr(8'h5C, 32'h000000FF);
      rc(8'h5C, 32'h0000000F, "irq_enable_set");
      rc(8'h58, 32'h0000000F, "irq_enable_clear");
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h58, 32'h1 << i);
         rc(8'h5C, 32'hF & ~(32'h1 << i), "irq_enable_set");
         wr(8'h5C, 32'h1 << i);
         rc(8'h58, 32'hF, "irq_enable_clear");
      end
      wr(8'h58, 32'hF);
      rc(8'h5C, 32'h0, "irq_enable_set");
      for (int i = 0; i < 32; i++)
      begin
         c = i[4:0];
         wr(8'h40, {19'h0, c, 3'h0, c});
         step;
         chk("pos_source", pexp(c), 32'(ps));
         chk("neg_source", nexp(c), 32'(ns));
         chk("sample_time", 32'(c == 5'h18 || c == 5'h19), 32'(stn));
         chk("pos_select", 32'(c), 32'(psel));
         chk("neg_select", 32'(c), 32'(nsel));
      end
      // lane 1 alone reaches only the negative select
      ws <= 4'h2;
      wr(8'h40, 32'h00000505);
      ws <= 4'hF;
      rc(8'h40, 32'h0000051F, "input_control");
      wr(8'h50, 32'h30);
      ev(5'b00010);
      chk("done_event", 32'h1, 32'(dev));
      step;
      chk("done_event", 32'h0, 32'(dev));
      ev(5'b00100);
      chk("range_event", 32'h1, 32'(rev));
      wr(8'h50, 32'h0);
      ev(5'b00110);
      chk("events_off", 32'h0, 32'({dev, rev}));
      wr(8'h50, 32'h1);
      ev(5'b00001);
      chk("start_flush", 32'h2, 32'({st, fl}));
      wr(8'h50, 32'h2);
      ev(5'b00001);
      chk("start_flush", 32'h1, 32'({st, fl}));
      step;
      chk("start_flush", 32'h2, 32'({st, fl}));
      wr(8'h50, 32'h0);
      ev(5'b00001);
      chk("start_flush", 32'h0, 32'({st, fl}));
      step;
      chk("start_flush", 32'h0, 32'({st, fl}));
      ev(5'b10000);
      wr(8'h60, 32'hF);
      wr(8'h5C, 32'h1);
      ev(5'b00010);
      step;
      chk("irq", 32'h1, 32'(irq));
      rc(8'h60, 32'h1, "irq_flag");
      wr(8'h58, 32'h1);
      step;
      chk("irq", 32'h0, 32'(irq));
      wr(8'h5C, 32'h1);
      step;
      chk("irq", 32'h1, 32'(irq));
      wr(8'h60, 32'h1);
      step;
      chk("irq", 32'h0, 32'(irq));
      ev(5'b00010);
      rc(8'h60, 32'h3, "irq_flag");
      ev(5'b10000);
      rc(8'h60, 32'h2, "irq_flag");
      wr(8'h60, 32'h2);
      rc(8'h60, 32'h0, "irq_flag");
      ev(5'b01100);
      wr(8'h5C, 32'h8);
      step;
      chk("irq", 32'h1, 32'(irq));
      rc(8'h60, 32'hC, "irq_flag");
      ev(5'b10000);
      wr(8'h60, 32'h8);
      chk("bresp", 32'h0, 32'(resp));
      rc(8'h60, 32'h0, "irq_flag");
      chk("rresp", 32'h0, 32'(resp));
      wr(8'h7C, 32'h1);
      chk("bresp", 32'h2, 32'(resp));
      rc(8'h7C, 32'h0, "unmapped");
      chk("rresp", 32'h2, 32'(resp));
      finish_test;
   end
endmodule

bind adci_ctrl adci_ctrl_monitor mon (.CLK_SYS(CLK_SYS), .RST(RST),
   .EVENT_IN(EVENT_IN), .CONV_DONE(CONV_DONE), .RANGE_MATCH(RANGE_MATCH),
   .CONV_START(CONV_START), .CONV_FLUSH(CONV_FLUSH),
   .CONV_DONE_EVENT(CONV_DONE_EVENT), .RANGE_MATCH_EVENT(RANGE_MATCH_EVENT),
   .POS_INPUT_SELECT(POS_INPUT_SELECT), .NEG_INPUT_SELECT(NEG_INPUT_SELECT),
   .POS_SOURCE(POS_SOURCE), .NEG_SOURCE(NEG_SOURCE),
   .SAMPLE_TIME_NEEDED(SAMPLE_TIME_NEEDED));
